// ### rseq_ctl_model.sv
`timescale 1ns/100ps

module rseq_ctl_model
    import rseq_pkg::*;
(
    input  wire logic       clk,
    input  wire rseq_pins_t want,
    output rseq_pins_t      pins
);
    // pins change only just after an edge of the design's own clock, so the design samples each change one edge later
    always @(posedge clk) begin
        pins <= want;
    end
endmodule

// ### rseq_defs.svh
`ifndef RSEQ_DEFS_SVH
`define RSEQ_DEFS_SVH

// register indices; byte address is four times the index
`define RSEQ_IDX_MASK_A   8'h0a
`define RSEQ_IDX_DLY2     8'h0c
`define RSEQ_IDX_SRC_B    8'h0e
`define RSEQ_IDX_DLY3     8'h0f
`define RSEQ_IDX_STATUS   8'h20

// reset values as loaded from the programmed defaults
`define RSEQ_RST_MASK_A   8'h00
`define RSEQ_RST_SRC_B    5'h00
`define RSEQ_RST_DLY      6'h00

// field positions
`define RSEQ_SRC_MSB      4
`define RSEQ_SRC_LSB      2
`define RSEQ_FALL_MSB     5
`define RSEQ_FALL_LSB     3
`define RSEQ_RISE_MSB     2
`define RSEQ_RISE_LSB     0

// enable source codes
`define RSEQ_SRC_CONTROL_INPUT_1     3'h0
`define RSEQ_SRC_CONTROL_INPUT_2     3'h1
`define RSEQ_SRC_CONTROL_INPUT_5     3'h2
`define RSEQ_SRC_CONTROL_INPUT_4     3'h3
`define RSEQ_SRC_CONTROL_INPUT_3     3'h4
`define RSEQ_SRC_CTL34    3'h5
`define RSEQ_SRC_CONTROL_INPUT_6     3'h6
`define RSEQ_SRC_ONE      3'h7

// edge delay steps in milliseconds
`define RSEQ_DLY_C1       7'h02
`define RSEQ_DLY_C2       7'h04
`define RSEQ_DLY_C3       7'h08
`define RSEQ_DLY_C4       7'h10
`define RSEQ_DLY_C5       7'h18
`define RSEQ_DLY_C6       7'h20
`define RSEQ_DLY_C7       7'h40

// time base
`define RSEQ_MS_NS        1000000
`define RSEQ_CLK_NS       10
`define RSEQ_CYC_PER_MS   ((`RSEQ_MS_NS + `RSEQ_CLK_NS - 1) / `RSEQ_CLK_NS)

`endif

// ### rseq_edge_delay.sv
`timescale 1ns/100ps
`include "rseq_defs.svh"

module rseq_edge_delay
    import rseq_pkg::*;
#(
    parameter int CYC_PER_MS = `RSEQ_CYC_PER_MS
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       req,
    input  wire logic [2:0] rise_code,
    input  wire logic [2:0] fall_code,
    output logic            en
);
    localparam int PW = $clog2(CYC_PER_MS + 1);

    typedef struct packed {
        rseq_edge_state_t st;
        logic [PW-1:0]    pre;
        logic [6:0]       ms;
        logic             en;
    } rseq_dly_state_t;

    localparam rseq_dly_state_t RST_STATE = '{st: RSEQ_LOW, pre: '0, ms: 7'h00, en: 1'b0};

    rseq_dly_state_t q;
    rseq_dly_state_t d;
    logic            tick;
    logic [6:0]      t_rise;
    logic [6:0]      t_fall;

    always_comb begin
        d = q;
        t_rise = rseq_delay_ms(rise_code);
        t_fall = rseq_delay_ms(fall_code);
        // millisecond tick restarts with each pending edge, keeping delays exact
        tick = (q.pre == PW'(CYC_PER_MS - 1));
        case (q.st)
            RSEQ_LOW: begin
                if (req) begin
                    d.pre = '0;
                    d.ms = 7'h00;
                    if (t_rise == 7'h00) begin
                        d.st = RSEQ_HIGH;
                        d.en = 1'b1;
                    end else begin
                        d.st = RSEQ_WRISE;
                    end
                end
            end
            RSEQ_WRISE: begin
                if (!req) begin
                    d.st = RSEQ_LOW;
                end else begin
                    d.pre = tick ? '0 : PW'(q.pre + 1'b1);
                    if (tick) begin
                        d.ms = 7'(q.ms + 1'b1);
                        if (7'(q.ms + 1'b1) >= t_rise) begin
                            d.st = RSEQ_HIGH;
                            d.en = 1'b1;
                        end
                    end
                end
            end
            RSEQ_HIGH: begin
                if (!req) begin
                    d.pre = '0;
                    d.ms = 7'h00;
                    if (t_fall == 7'h00) begin
                        d.st = RSEQ_LOW;
                        d.en = 1'b0;
                    end else begin
                        d.st = RSEQ_WFALL;
                    end
                end
            end
            RSEQ_WFALL: begin
                if (req) begin
                    d.st = RSEQ_HIGH;
                end else begin
                    d.pre = tick ? '0 : PW'(q.pre + 1'b1);
                    if (tick) begin
                        d.ms = 7'(q.ms + 1'b1);
                        if (7'(q.ms + 1'b1) >= t_fall) begin
                            d.st = RSEQ_LOW;
                            d.en = 1'b0;
                        end
                    end
                end
            end
            default: begin
                d = RST_STATE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= RST_STATE;
        end else begin
            q <= d;
        end
    end

    assign en = q.en;

    // cycles spent waiting, for timing checks only
    logic [31:0] h_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            h_q <= 32'h0;
        end else begin
            h_q <= (q.st == RSEQ_WRISE || q.st == RSEQ_WFALL) ? h_q + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_rise_exact_time: assert property (
        $rose(q.en) && $past(q.st == RSEQ_WRISE)
        |-> $past(h_q) == $past(32'(t_rise)) * CYC_PER_MS - 1)
        else $error("rise delay length wrong");
    a_fall_exact_time: assert property (
        $fell(q.en) && $past(q.st == RSEQ_WFALL)
        |-> $past(h_q) == $past(32'(t_fall)) * CYC_PER_MS - 1)
        else $error("fall delay length wrong");
    a_rise_no_delay: assert property (
        q.st == RSEQ_LOW && req && rise_code == 3'h0 |=> q.en)
        else $error("zero rise delay not immediate");
    a_pending_restart: assert property (
        q.st == RSEQ_WRISE && !req |=> q.st == RSEQ_LOW && !q.en)
        else $error("pending rise not cancelled");
    a_rise_needs_req: assert property (
        $rose(q.en) |-> $past(req))
        else $error("enable rose without request");
    a_tick_base: assert property (
        q.st == RSEQ_WRISE && req && $past(q.st) == RSEQ_LOW
        |-> q.pre == '0 && q.ms == 7'h00)
        else $error("time base not restarted");
    c_delayed_rise: cover property ($rose(q.en) && $past(q.st == RSEQ_WRISE));
    c_restart: cover property (q.st == RSEQ_WFALL ##1 q.st == RSEQ_HIGH);
endmodule

// ### rseq_pin_sync.sv
`timescale 1ns/100ps

module rseq_pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] v;
    } rseq_sync_state_t;

    rseq_sync_state_t q;
    rseq_sync_state_t d;

    // a bit changes only once the second and third stages agree
    always_comb begin
        d = q;
        d.s1 = din;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.v = (q.s2 & q.s3) | (q.v & (q.s2 ^ q.s3));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dout = q.v;
endmodule

// ### rseq_pkg.sv
`include "rseq_defs.svh"

package rseq_pkg;

    typedef enum logic [3:0] {
        RSEQ_LOW   = 4'h1,
        RSEQ_WRISE = 4'h2,
        RSEQ_HIGH  = 4'h4,
        RSEQ_WFALL = 4'h8
    } rseq_edge_state_t;

    typedef struct packed {
        logic       act;
        logic       wr;
        logic [7:0] idx;
    } rseq_aphase_t;

    typedef struct packed {
        logic [5:0] ctl;
        logic [7:0] pg_a;
        logic [1:0] pg_b;
        logic       rail2_req;
    } rseq_pins_t;

    function automatic logic [6:0] rseq_delay_ms(input logic [2:0] code);
        case (code)
            3'h1:    rseq_delay_ms = `RSEQ_DLY_C1;
            3'h2:    rseq_delay_ms = `RSEQ_DLY_C2;
            3'h3:    rseq_delay_ms = `RSEQ_DLY_C3;
            3'h4:    rseq_delay_ms = `RSEQ_DLY_C4;
            3'h5:    rseq_delay_ms = `RSEQ_DLY_C5;
            3'h6:    rseq_delay_ms = `RSEQ_DLY_C6;
            3'h7:    rseq_delay_ms = `RSEQ_DLY_C7;
            default: rseq_delay_ms = 7'h00;
        endcase
    endfunction

endpackage

// ### rseq_top.sv
// Summary of operation
// - The rail 3 source field picks input 1, 2, 5, 4, 3, inputs 3 and 4 together, or input 6 for codes 000 to 110.
// - Source code 111 feeds a constant one, so rail 3 enables without any control pin.
// - A power-good mask bit of 0 makes that rail's power-good a condition of the enable; 1 removes it.
// - Mask register A holds masks for aux regulator 3, 2, load switch A and rails 6, 5, 4, 2, 1 at bits 7 to 0.
// - Register B holds the source select at bits 4:2, the switch B2 regulator mask at 1, switch B1 mask at 0.
// - Rail 3's enable falling edge is delayed by code 5:3: none, 2, 4, 8, 16, 24, 32 or 64 ms.
// - Rail 3's enable rising edge is delayed by code 2:0 with the same table.
// - Rail 2's enable falling edge is delayed by code 5:3 with the same table.
// - Rail 2's enable rising edge is delayed by code 2:0 with the same table.
// - Delays may be up to ten percent off nominal, so the time base need only be that accurate.
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/100ps
`include "rseq_defs.svh"

module rseq_top
    import rseq_pkg::*;
#(
    parameter int ADDR_W     = 10,
    parameter int CYC_PER_MS = `RSEQ_CYC_PER_MS
) (
    input  wire logic              CORE_CLK,
    input  wire logic              SYS_RST,
    input  wire logic              HSEL,
    input  wire logic [ADDR_W-1:0] HADDR,
    input  wire logic [1:0]        HTRANS,
    input  wire logic              HWRITE,
    input  wire logic [2:0]        HSIZE,
    input  wire logic [31:0]       HWDATA,
    input  wire logic              HREADY,
    output logic      [31:0]       HRDATA,
    output logic                   HREADYOUT,
    output logic                   HRESP,
    input  wire logic [5:0]        CONTROL_INPUT,
    input  wire logic [7:0]        POWER_GOOD_A,
    input  wire logic [1:0]        POWER_GOOD_B,
    input  wire logic              RAIL2_QUALIFIED_REQ,
    output logic                   RAIL3_ENABLE,
    output logic                   RAIL2_ENABLE
);
    typedef struct packed {
        rseq_aphase_t ap;
        logic [7:0]   mask_a;
        logic [4:0]   src_b;
        logic [5:0]   dly3;
        logic [5:0]   dly2;
        logic [31:0]  rdata;
        logic         ready;
        logic         resp;
    } rseq_top_state_t;

    localparam rseq_top_state_t RST_STATE = '{
        ap:     '0,
        mask_a: `RSEQ_RST_MASK_A,
        src_b:  `RSEQ_RST_SRC_B,
        dly3:   `RSEQ_RST_DLY,
        dly2:   `RSEQ_RST_DLY,
        rdata:  32'h0,
        ready:  1'b1,
        resp:   1'b0
    };

    rseq_top_state_t q;
    rseq_top_state_t d;
    rseq_pins_t      raw;
    rseq_pins_t      pins;
    logic [2:0]      src_sel;
    logic            src_level;
    logic            pg_ok;
    logic            qual3;
    logic            en3;
    logic            en2;

    assign raw = '{ctl: CONTROL_INPUT, pg_a: POWER_GOOD_A, pg_b: POWER_GOOD_B,
                   rail2_req: RAIL2_QUALIFIED_REQ};

    rseq_pin_sync #(
        .W ($bits(rseq_pins_t))
    ) u_sync (
        .clk  (CORE_CLK),
        .rst  (SYS_RST),
        .din  (raw),
        .dout (pins)
    );

    // enable source selection and power-good qualification
    always_comb begin
        src_sel = q.src_b[`RSEQ_SRC_MSB:`RSEQ_SRC_LSB];
        case (src_sel)
            `RSEQ_SRC_CONTROL_INPUT_1:  src_level = pins.ctl[0];
            `RSEQ_SRC_CONTROL_INPUT_2:  src_level = pins.ctl[1];
            `RSEQ_SRC_CONTROL_INPUT_5:  src_level = pins.ctl[4];
            `RSEQ_SRC_CONTROL_INPUT_4:  src_level = pins.ctl[3];
            `RSEQ_SRC_CONTROL_INPUT_3:  src_level = pins.ctl[2];
            `RSEQ_SRC_CTL34: src_level = pins.ctl[2] & pins.ctl[3];
            `RSEQ_SRC_CONTROL_INPUT_6:  src_level = pins.ctl[5];
            `RSEQ_SRC_ONE:   src_level = 1'b1;
            default:         src_level = 1'b0;
        endcase
        pg_ok = &({pins.pg_a, pins.pg_b} | {q.mask_a, q.src_b[1:0]});
        qual3 = src_level & pg_ok;
    end

    rseq_edge_delay #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_rail3 (
        .clk       (CORE_CLK),
        .rst       (SYS_RST),
        .req       (qual3),
        .rise_code (q.dly3[`RSEQ_RISE_MSB:`RSEQ_RISE_LSB]),
        .fall_code (q.dly3[`RSEQ_FALL_MSB:`RSEQ_FALL_LSB]),
        .en        (en3)
    );

    rseq_edge_delay #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_rail2 (
        .clk       (CORE_CLK),
        .rst       (SYS_RST),
        .req       (pins.rail2_req),
        .rise_code (q.dly2[`RSEQ_RISE_MSB:`RSEQ_RISE_LSB]),
        .fall_code (q.dly2[`RSEQ_FALL_MSB:`RSEQ_FALL_LSB]),
        .en        (en2)
    );

    // bus slave: zero wait states, reads see a write made in the cycle before
    always_comb begin
        d = q;
        d.ap.act = HSEL & HTRANS[1] & HREADY;
        d.ap.wr = HWRITE;
        d.ap.idx = 8'(HADDR[ADDR_W-1:2]);
        d.ready = 1'b1;
        d.resp = 1'b0;
        if (q.ap.act && q.ap.wr) begin
            case (q.ap.idx)
                `RSEQ_IDX_MASK_A: d.mask_a = HWDATA[7:0];
                `RSEQ_IDX_SRC_B:  d.src_b = HWDATA[4:0];
                `RSEQ_IDX_DLY3:   d.dly3 = HWDATA[5:0];
                `RSEQ_IDX_DLY2:   d.dly2 = HWDATA[5:0];
                default:          d.dly2 = q.dly2;
            endcase
        end
        d.rdata = 32'h0;
        if (d.ap.act && !d.ap.wr) begin
            case (d.ap.idx)
                `RSEQ_IDX_MASK_A: d.rdata = {24'h0, d.mask_a};
                `RSEQ_IDX_SRC_B:  d.rdata = {27'h0, d.src_b};
                `RSEQ_IDX_DLY3:   d.rdata = {26'h0, d.dly3};
                `RSEQ_IDX_DLY2:   d.rdata = {26'h0, d.dly2};
                `RSEQ_IDX_STATUS: d.rdata = {21'h0, pins.ctl, pins.rail2_req, pg_ok, qual3, en2, en3};
                default:          d.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            q <= RST_STATE;
        end else begin
            q <= d;
        end
    end

    assign HRDATA = q.rdata;
    assign HREADYOUT = q.ready;
    assign HRESP = q.resp;
    assign RAIL3_ENABLE = en3;
    assign RAIL2_ENABLE = en2;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);

    a_src_pin_pick: assert property (
        src_sel == `RSEQ_SRC_CONTROL_INPUT_5 |-> qual3 == (pins.ctl[4] & pg_ok))
        else $error("input 5 not selected");
    a_src_pin_pair: assert property (
        src_sel == `RSEQ_SRC_CTL34 |-> qual3 == (pins.ctl[2] & pins.ctl[3] & pg_ok))
        else $error("inputs 3 and 4 not combined");
    a_src_const_one: assert property (
        src_sel == `RSEQ_SRC_ONE && pg_ok |-> qual3)
        else $error("constant source not enabling");
    a_mask_blocks_en: assert property (
        |(~{pins.pg_a, pins.pg_b} & ~{q.mask_a, q.src_b[1:0]}) |-> !qual3)
        else $error("unmasked bad power-good ignored");
    a_mask_a_write: assert property (
        q.ap.act && q.ap.wr && q.ap.idx == `RSEQ_IDX_MASK_A |=> q.mask_a == $past(HWDATA[7:0]))
        else $error("mask register A not written");
    a_src_b_write: assert property (
        q.ap.act && q.ap.wr && q.ap.idx == `RSEQ_IDX_SRC_B |=> src_sel == $past(HWDATA[4:2]))
        else $error("source field not written");
    a_dly2_write: assert property (
        q.ap.act && q.ap.wr && q.ap.idx == `RSEQ_IDX_DLY2 |=> q.dly2 == $past(HWDATA[5:0]))
        else $error("rail 2 delays not written");
    a_read_data: assert property (
        d.ap.act && !d.ap.wr && d.ap.idx == `RSEQ_IDX_DLY3 |=> HRDATA == {26'h0, $past(d.dly3)})
        else $error("delay read data wrong");
    c_const_source: cover property (src_sel == `RSEQ_SRC_ONE && qual3);
    c_rail3_rise: cover property ($rose(RAIL3_ENABLE));
    c_rail2_fall: cover property ($fell(RAIL2_ENABLE));
endmodule

// ### rseq_top_bench.sv
`timescale 1ns/100ps
`include "rseq_defs.svh"

module rseq_top_bench
    import rseq_pkg::*;
;
    localparam int CYC = 4;
    // edges from the driving edge to the enable change with no delay programmed
    localparam int LAT = 6;

    logic        clk       = 1'b0;
    logic        rst       = 1'b1;
    logic        hsel      = 1'b0;
    logic [9:0]  haddr     = 10'h0;
    logic [1:0]  htrans    = 2'h0;
    logic        hwrite    = 1'b0;
    logic [31:0] hwdata    = 32'h0;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic        en3;
    logic        en2;
    rseq_pins_t  want      = '0;
    rseq_pins_t  pins;
    int          err_total = 0;
    int          checks    = 0;
    logic [31:0] rd;
    logic [7:0]  ma;
    logic [7:0]  pa;
    logic [1:0]  mb;
    logic [1:0]  pb;
    logic [5:0]  v;
    int          n;
    logic [7:0]  ix[4]     = '{`RSEQ_IDX_MASK_A, `RSEQ_IDX_SRC_B, `RSEQ_IDX_DLY3, `RSEQ_IDX_DLY2};
    logic [31:0] km[4]     = '{32'hff, 32'h1f, 32'h3f, 32'h3f};
    logic [31:0] rv[4]     = '{32'(`RSEQ_RST_MASK_A), 32'(`RSEQ_RST_SRC_B), 32'(`RSEQ_RST_DLY), 32'(`RSEQ_RST_DLY)};

    initial begin
        forever #5 clk = ~clk;
    end

    rseq_top #(
        .ADDR_W     (10),
        .CYC_PER_MS (CYC)
    ) DUT (
        .CORE_CLK            (clk),
        .SYS_RST             (rst),
        .HSEL                (hsel),
        .HADDR               (haddr),
        .HTRANS              (htrans),
        .HWRITE              (hwrite),
        .HSIZE               (3'h2),
        .HWDATA              (hwdata),
        .HREADY              (hready),
        .HRDATA              (hrdata),
        .HREADYOUT           (hready),
        .HRESP               (hresp),
        .CONTROL_INPUT       (pins.ctl),
        .POWER_GOOD_A        (pins.pg_a),
        .POWER_GOOD_B        (pins.pg_b),
        .RAIL2_QUALIFIED_REQ (pins.rail2_req),
        .RAIL3_ENABLE        (en3),
        .RAIL2_ENABLE        (en2)
    );

    rseq_ctl_model ctl_model (
        .clk  (clk),
        .want (want),
        .pins (pins)
    );

    task automatic finish_test();
        if (err_total == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic fail(input string m);
        err_total++;
        $display("Error at %0t: %s", $time, m);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            fail(m);
        end
    endtask

    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hready !== 1'b1 && k < 50);
        if (hready !== 1'b1) begin
            fail("bus timeout");
            finish_test();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {idx, 2'h0};
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        if (hresp !== 1'b0) begin
            fail("error response");
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input string m);
        bus(1'b0, idx, 32'h0);
        chk(rd, exp, m);
    endtask

    // counts edges until the chosen enable reaches lvl and compares with exp, one cycle of slack
    task automatic edge_time(input logic r2, input logic lvl, input int exp, input string m);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (((r2 ? en2 : en3) !== lvl) && k < 2000);
        if ((r2 ? en2 : en3) !== lvl) begin
            fail("enable timeout");
            finish_test();
        end
        checks++;
        if (k < exp - 1 || k > exp + 1) begin
            fail(m);
        end
    endtask

    function automatic int ms_of(input logic [2:0] c);
        int t[8] = '{0, 2, 4, 8, 16, 24, 32, 64};
        return t[c];
    endfunction

    function automatic logic src_exp(input logic [2:0] c, input logic [5:0] p);
        case (c)
            3'h0:    return p[0];
            3'h1:    return p[1];
            3'h2:    return p[4];
            3'h3:    return p[3];
            3'h4:    return p[2];
            3'h5:    return p[2] & p[3];
            3'h6:    return p[5];
            default: return 1'b1;
        endcase
    endfunction

    initial begin
        void'($urandom(32'hb6d8));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rdchk(ix[i], rv[i], "register reset value");
        end
        for (int j = 0; j < 3; j++) begin
            for (int i = 0; i < 4; i++) begin
                n = $urandom;
                wr(ix[i], 32'(n));
                rdchk(ix[i], 32'(n) & km[i], "register read back");
            end
        end
        wr(8'h15, 32'hffffffff);
        rdchk(8'h15, 32'h0, "unmapped read");
        // source selection with every power-good masked off
        wr(`RSEQ_IDX_MASK_A, 32'hff);
        wr(`RSEQ_IDX_DLY3, 32'h0);
        for (int c = 0; c < 8; c++) begin
            wr(`RSEQ_IDX_SRC_B, 32'({3'(c), 2'h3}));
            for (int p = 0; p < 3; p++) begin
                @(posedge clk);
                v = (p == 0) ? 6'($urandom) : (p == 1) ? ~v : 6'h0c;
                want.ctl <= v;
                repeat (12) @(posedge clk);
                #1;
                chk(32'(en3), 32'(src_exp(3'(c), v)), "source select");
            end
        end
        // power-good qualification under the constant-one source
        for (int i = 0; i < 12; i++) begin
            ma = (i == 0) ? 8'hff : (i == 1) ? 8'h7f : 8'($urandom);
            mb = (i == 0) ? 2'h2 : (i == 1) ? 2'h3 : 2'($urandom);
            pa = (i == 1) ? 8'h7f : 8'($urandom | $urandom);
            pb = (i == 0) ? 2'h2 : 2'($urandom | $urandom);
            wr(`RSEQ_IDX_MASK_A, 32'(ma));
            wr(`RSEQ_IDX_SRC_B, 32'({3'h7, mb}));
            @(posedge clk);
            want.pg_a <= pa;
            want.pg_b <= pb;
            repeat (12) @(posedge clk);
            #1;
            chk(32'(en3), 32'((&(pa | ma)) & (&(pb | mb))), "power-good mask");
        end
        // edge delays of both rails for every code
        wr(`RSEQ_IDX_MASK_A, 32'hff);
        wr(`RSEQ_IDX_SRC_B, 32'h3);
        @(posedge clk);
        want.ctl <= 6'h0;
        repeat (12) @(posedge clk);
        for (int c = 0; c < 8; c++) begin
            wr(`RSEQ_IDX_DLY3, 32'({3'(c), 3'(c)}));
            wr(`RSEQ_IDX_DLY2, 32'({3'(c), 3'(c)}));
            @(posedge clk);
            want.ctl[0] <= 1'b1;
            edge_time(1'b0, 1'b1, LAT + ms_of(3'(c)) * CYC, "rail3 rise delay");
            @(posedge clk);
            want.ctl[0] <= 1'b0;
            edge_time(1'b0, 1'b0, LAT + ms_of(3'(c)) * CYC, "rail3 fall delay");
            @(posedge clk);
            want.rail2_req <= 1'b1;
            edge_time(1'b1, 1'b1, LAT + ms_of(3'(c)) * CYC, "rail2 rise delay");
            @(posedge clk);
            want.rail2_req <= 1'b0;
            edge_time(1'b1, 1'b0, LAT + ms_of(3'(c)) * CYC, "rail2 fall delay");
        end
        // a request withdrawn before expiry is dropped, and a new one waits the full delay
        wr(`RSEQ_IDX_DLY3, 32'h4);
        @(posedge clk);
        want.ctl[0] <= 1'b1;
        repeat (10) @(posedge clk);
        want.ctl[0] <= 1'b0;
        n = 0;
        repeat (80) begin
            @(posedge clk);
            #1;
            if (en3 !== 1'b0) begin
                n++;
            end
        end
        chk(32'(n), 32'h0, "cancelled rise reached output");
        @(posedge clk);
        want.ctl[0] <= 1'b1;
        edge_time(1'b0, 1'b1, LAT + ms_of(3'h4) * CYC, "restarted rise delay");
        // input 1 high, all masked, rail 3 up, rail 2 down
        rdchk(`RSEQ_IDX_STATUS, 32'h2d, "status read");
        // reset in mid-run drops the enable and restores the registers
        @(posedge clk);
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk(32'(en3), 32'h0, "enable after reset");
        rdchk(`RSEQ_IDX_DLY3, rv[2], "delay reset value");
        finish_test();
    end
endmodule
